/* src/mlsd_pkg.sv */
// Functional notes
// - Opcodes 4 to 7 are load/store space; sub-opcode is bits 35:30.
// - Opcode 4 uses bits 36 and 27 as integer subgroup selectors.
// - Opcode 6 uses bits 36 and 27 as floating-point subgroup selectors.
// - Opcode 4: 00 plain, 01 semaphore/get-FP, 10 +reg, 11 unassigned.
// - Opcode 6: 00 FP load/store, 01 pair/set-FP, 10 +reg, 11 pair +imm.
// - Bits 29:28 locality hint passes through beside the operation select.
// - Load row 35:32: normal, spec, adv, spec-adv, bias, acquire.
// - Single pair load accesses 8 bytes; double and integer pairs 16 bytes.
// - FP store +imm writes to base address, then adds 9-bit immediate.
package mlsd_pkg;

  localparam int IW = 41;

  localparam int OPC_HI = 40;
  localparam int OPC_LO = 37;
  localparam int SEL_M  = 36;
  localparam int SEL_X  = 27;
  localparam int SUB_HI = 35;
  localparam int SUB_LO = 30;
  localparam int ROW_LO = 32;
  localparam int HINT_HI = 29;
  localparam int HINT_LO = 28;
  localparam int LIMM_HI = 19;
  localparam int LIMM_LO = 13;
  localparam int SIMM_HI = 12;
  localparam int SIMM_LO = 6;

  localparam logic [3:0] OPC_INT     = 4'h4;
  localparam logic [3:0] OPC_INT_IMM = 4'h5;
  localparam logic [3:0] OPC_FP      = 4'h6;
  localparam logic [3:0] OPC_FP_IMM  = 4'h7;

  localparam logic [1:0] GRP_PLAIN = 2'h0;
  localparam logic [1:0] GRP_SEMA  = 2'h1;
  localparam logic [1:0] GRP_REG   = 2'h2;
  localparam logic [1:0] GRP_PIMM  = 2'h3;

  // Sub-opcode rows: loads 0..5, stores, move-to/from FP
  localparam logic [3:0] ROW_LOAD_LAST = 4'h5;
  localparam logic [3:0] ROW_STORE     = 4'hC;
  localparam logic [3:0] ROW_STORE_REL = 4'hD;
  localparam logic [3:0] ROW_FPMOVE    = 4'h7;

  // Pair format in sub-opcode low bits
  localparam logic [1:0] PAIR_INT    = 2'h1;
  localparam logic [1:0] PAIR_SINGLE = 2'h2;
  localparam logic [1:0] PAIR_DOUBLE = 2'h3;

  localparam logic [4:0] SIZE_PAIR_SINGLE = 5'h08;
  localparam logic [4:0] SIZE_PAIR_WIDE   = 5'h10;
  localparam logic [4:0] SIZE_FP_EXT      = 5'h10;
  localparam logic [4:0] SIZE_FP_INT      = 5'h08;
  localparam logic [4:0] SIZE_FP_SINGLE   = 5'h04;
  localparam logic [4:0] SIZE_FP_DOUBLE   = 5'h08;
  localparam logic [4:0] SIZE_FP_MOVE     = 5'h08;
  localparam logic [4:0] SIZE_NONE        = 5'h00;

  typedef enum logic [3:0] {
    MLSD_OP_NONE,
    MLSD_OP_INT_LOAD,
    MLSD_OP_INT_STORE,
    MLSD_OP_SEMAPHORE,
    MLSD_OP_FP_TO_GR,
    MLSD_OP_FP_LOAD,
    MLSD_OP_FP_STORE,
    MLSD_OP_FP_PAIR_LOAD,
    MLSD_OP_GR_TO_FP
  } mlsd_op_e;

  typedef enum logic [2:0] {
    MLSD_VAR_NORMAL,
    MLSD_VAR_SPECULATIVE,
    MLSD_VAR_ADVANCED,
    MLSD_VAR_SPEC_ADVANCED,
    MLSD_VAR_BIAS,
    MLSD_VAR_ACQUIRE,
    MLSD_VAR_RELEASE
  } mlsd_var_e;

  typedef enum logic [1:0] {
    MLSD_UPD_NONE,
    MLSD_UPD_REG,
    MLSD_UPD_IMM
  } mlsd_upd_e;

endpackage

/* src/mlsd_decode.sv */
`timescale 1ns/1ps
module mlsd_decode (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 clk_en,
  input  wire logic                 instr_valid,
  input  wire logic [mlsd_pkg::IW-1:0] instr,
  output logic                      dec_valid,
  output mlsd_pkg::mlsd_op_e        op_class,
  output mlsd_pkg::mlsd_var_e       op_variant,
  output mlsd_pkg::mlsd_upd_e       base_update,
  output logic [4:0]                access_bytes,
  output logic [1:0]                locality_hint,
  output logic [8:0]                update_imm,
  output logic                      is_load,
  output logic                      is_store,
  output logic                      illegal_op
);
  import mlsd_pkg::*;

  logic [3:0] opc;
  logic [1:0] grp;
  logic [5:0] six_bit_subop;
  logic [3:0] row;
  logic [1:0] sz_code;
  logic [8:0] load_imm;
  logic [8:0] store_imm;

  mlsd_op_e   next_op;
  mlsd_var_e  next_var;
  mlsd_upd_e  next_upd;
  logic [4:0] next_bytes;
  logic [8:0] next_imm;
  logic       next_illegal;
  logic       in_space;

  assign opc           = instr[OPC_HI:OPC_LO];
  assign six_bit_subop = instr[SUB_HI:SUB_LO];
  assign row           = instr[SUB_HI:ROW_LO];
  assign sz_code       = instr[ROW_LO-1:SUB_LO];
  assign in_space      = (opc >= OPC_INT) && (opc <= OPC_FP_IMM);
  assign grp           = {instr[SEL_M], instr[SEL_X]};
  // Opcode 5 and 7 immediate forms reuse the selector bits as the top of imm9
  assign load_imm  = {instr[SEL_M], instr[SEL_X], instr[LIMM_HI:LIMM_LO]};
  assign store_imm = {instr[SEL_M], instr[SEL_X], instr[SIMM_HI:SIMM_LO]};

  function automatic logic [4:0] int_bytes(input logic [1:0] code);
    int_bytes = 5'h01 << code;
  endfunction

  function automatic logic [4:0] fp_bytes(input logic [1:0] code);
    unique case (code)
      2'h0: fp_bytes = SIZE_FP_EXT;
      2'h1: fp_bytes = SIZE_FP_INT;
      2'h2: fp_bytes = SIZE_FP_SINGLE;
      2'h3: fp_bytes = SIZE_FP_DOUBLE;
    endcase
  endfunction

  function automatic mlsd_var_e load_var(input logic [3:0] r);
    // Load variant from upper sub-opcode bits
    unique case (r)
      4'h0:    load_var = MLSD_VAR_NORMAL;
      4'h1:    load_var = MLSD_VAR_SPECULATIVE;
      4'h2:    load_var = MLSD_VAR_ADVANCED;
      4'h3:    load_var = MLSD_VAR_SPEC_ADVANCED;
      4'h4:    load_var = MLSD_VAR_BIAS;
      4'h5:    load_var = MLSD_VAR_ACQUIRE;
      default: load_var = MLSD_VAR_NORMAL;
    endcase
  endfunction

  always_comb begin
    next_op      = MLSD_OP_NONE;
    next_var     = MLSD_VAR_NORMAL;
    next_upd     = MLSD_UPD_NONE;
    next_bytes   = SIZE_NONE;
    next_imm     = 9'h000;
    next_illegal = 1'b0;
    unique case (opc)
      OPC_INT: begin
        unique case (grp)
          GRP_PLAIN, GRP_REG: begin
            next_upd = (grp == GRP_REG) ? MLSD_UPD_REG : MLSD_UPD_NONE;
            if (row <= ROW_LOAD_LAST) begin
              next_op    = MLSD_OP_INT_LOAD;
              next_var   = load_var(row);
              next_bytes = int_bytes(sz_code);
            end else if ((grp == GRP_PLAIN) &&
                         ((row == ROW_STORE) || (row == ROW_STORE_REL))) begin
              next_op    = MLSD_OP_INT_STORE;
              next_var   = (row == ROW_STORE_REL) ? MLSD_VAR_RELEASE
                                                  : MLSD_VAR_NORMAL;
              next_bytes = int_bytes(sz_code);
            end else begin
              next_illegal = 1'b1;
              next_upd     = MLSD_UPD_NONE;
            end
          end
          GRP_SEMA: begin
            if (row == ROW_FPMOVE) begin
              next_op    = MLSD_OP_FP_TO_GR;
              next_bytes = SIZE_FP_MOVE;
            end else begin
              next_op    = MLSD_OP_SEMAPHORE;
              next_bytes = int_bytes(sz_code);
            end
          end
          GRP_PIMM: begin
            next_illegal = 1'b1;
          end
        endcase
      end
      OPC_INT_IMM: begin
        next_upd = MLSD_UPD_IMM;
        if (row <= ROW_LOAD_LAST) begin
          next_op    = MLSD_OP_INT_LOAD;
          next_var   = load_var(row);
          next_bytes = int_bytes(sz_code);
          next_imm   = load_imm;
        end else if ((row == ROW_STORE) || (row == ROW_STORE_REL)) begin
          next_op    = MLSD_OP_INT_STORE;
          next_var   = (row == ROW_STORE_REL) ? MLSD_VAR_RELEASE
                                              : MLSD_VAR_NORMAL;
          next_bytes = int_bytes(sz_code);
          next_imm   = store_imm;
        end else begin
          next_illegal = 1'b1;
          next_upd     = MLSD_UPD_NONE;
        end
      end
      OPC_FP: begin
        unique case (grp)
          GRP_PLAIN, GRP_REG: begin
            next_upd = (grp == GRP_REG) ? MLSD_UPD_REG : MLSD_UPD_NONE;
            if (row <= ROW_LOAD_LAST) begin
              next_op    = MLSD_OP_FP_LOAD;
              next_var   = load_var(row);
              next_bytes = fp_bytes(sz_code);
            end else if ((grp == GRP_PLAIN) && (row == ROW_STORE)) begin
              next_op    = MLSD_OP_FP_STORE;
              next_bytes = fp_bytes(sz_code);
            end else begin
              next_illegal = 1'b1;
              next_upd     = MLSD_UPD_NONE;
            end
          end
          GRP_SEMA, GRP_PIMM: begin
            if ((grp == GRP_SEMA) && (row == ROW_FPMOVE)) begin
              next_op    = MLSD_OP_GR_TO_FP;
              next_bytes = SIZE_FP_MOVE;
            end else if ((row <= ROW_LOAD_LAST) && (sz_code != 2'h0)) begin
              next_op  = MLSD_OP_FP_PAIR_LOAD;
              next_var = load_var(row);
              next_upd = (grp == GRP_PIMM) ? MLSD_UPD_IMM : MLSD_UPD_NONE;
              next_bytes = (sz_code == PAIR_SINGLE) ? SIZE_PAIR_SINGLE
                                                    : SIZE_PAIR_WIDE;
            end else begin
              next_illegal = 1'b1;
            end
          end
        endcase
      end
      OPC_FP_IMM: begin
        next_upd = MLSD_UPD_IMM;
        if (row <= ROW_LOAD_LAST) begin
          next_op    = MLSD_OP_FP_LOAD;
          next_var   = load_var(row);
          next_bytes = fp_bytes(sz_code);
          next_imm   = load_imm;
        end else if (row == ROW_STORE) begin
          // Store to base, then base += imm9
          next_op    = MLSD_OP_FP_STORE;
          next_bytes = fp_bytes(sz_code);
          next_imm   = store_imm;
        end else begin
          next_illegal = 1'b1;
          next_upd     = MLSD_UPD_NONE;
        end
      end
      default: begin
        next_op = MLSD_OP_NONE;
      end
    endcase
  end

  // Valid only follows instructions of the load/store space
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid <= 1'b0;
    end else if (clk_en) begin
      dec_valid <= instr_valid && in_space;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      op_class     <= MLSD_OP_NONE;
      op_variant   <= MLSD_VAR_NORMAL;
      base_update  <= MLSD_UPD_NONE;
      access_bytes <= SIZE_NONE;
      update_imm   <= 9'h000;
      illegal_op   <= 1'b0;
      is_load      <= 1'b0;
      is_store     <= 1'b0;
    end else if (clk_en) begin
      op_class     <= next_op;
      op_variant   <= next_var;
      base_update  <= next_upd;
      access_bytes <= next_bytes;
      update_imm   <= next_imm;
      illegal_op   <= instr_valid && in_space && next_illegal;
      is_load      <= (next_op == MLSD_OP_INT_LOAD) ||
                      (next_op == MLSD_OP_FP_LOAD) ||
                      (next_op == MLSD_OP_FP_PAIR_LOAD) ||
                      (next_op == MLSD_OP_SEMAPHORE);
      is_store     <= (next_op == MLSD_OP_INT_STORE) ||
                      (next_op == MLSD_OP_FP_STORE) ||
                      (next_op == MLSD_OP_SEMAPHORE);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      locality_hint <= 2'h0;
    end else if (clk_en) begin
      locality_hint <= instr[HINT_HI:HINT_LO];
    end
  end

endmodule // mlsd_decode

/* verif/mlsd_decode_chk.sv */
`timescale 1ns/1ps
module mlsd_decode_chk (
  input wire logic                   clk_sys,
  input wire logic                   rst_b,
  input wire logic                   clk_en,
  input wire logic                   instr_valid,
  input wire logic [mlsd_pkg::IW-1:0] instr,
  input wire logic                   dec_valid,
  input mlsd_pkg::mlsd_op_e          op_class,
  input mlsd_pkg::mlsd_var_e         op_variant,
  input mlsd_pkg::mlsd_upd_e         base_update,
  input wire logic [4:0]             access_bytes,
  input wire logic [1:0]             locality_hint,
  input wire logic [8:0]             update_imm,
  input wire logic                   is_load,
  input wire logic                   is_store,
  input wire logic                   illegal_op
);
  import mlsd_pkg::*;
  wire       go  = clk_en && instr_valid;
  wire [3:0] opc = instr[40:37];
  wire [3:0] row = instr[35:32];
  wire [1:0] sel = {instr[36], instr[27]};
  wire [1:0] cod = instr[31:30];
  wire       ld  = row <= ROW_LOAD_LAST;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_space_valid: assert property (
    go && opc[3:2] == 2'h1 |=> dec_valid)
    else $error("load/store word not marked valid");
  a_refuse_out: assert property (
    clk_en && opc[3:2] != 2'h1 |=>
    !dec_valid && !illegal_op && op_class == MLSD_OP_NONE)
    else $error("word outside space decoded");
  a_hint_copy: assert property (
    clk_en |=> locality_hint == $past(instr[29:28]))
    else $error("hint not passed");
  a_int_unassigned: assert property (
    go && opc == OPC_INT && sel == 2'h3 |=> illegal_op && dec_valid)
    else $error("selector 11 not illegal");
  a_int_variant: assert property (
    go && opc == OPC_INT && sel == 2'h0 && ld |=>
    op_class == MLSD_OP_INT_LOAD && op_variant == $past(instr[34:32]) &&
    access_bytes == (5'h01 << $past(cod)))
    else $error("int load wrong");
  a_store_release: assert property (
    go && opc == OPC_INT && sel == 2'h0 && row == ROW_STORE_REL |=>
    op_class == MLSD_OP_INT_STORE && op_variant == MLSD_VAR_RELEASE)
    else $error("release store wrong");
  a_int_regupd: assert property (
    go && opc == OPC_INT && sel == 2'h2 && ld |=>
    base_update == MLSD_UPD_REG)
    else $error("+reg load wrong");
  a_pair_size: assert property (
    go && opc == OPC_FP && sel[0] && ld && cod != 2'h0 |=>
    op_class == MLSD_OP_FP_PAIR_LOAD && access_bytes ==
    ($past(cod) == PAIR_SINGLE ? SIZE_PAIR_SINGLE : SIZE_PAIR_WIDE))
    else $error("pair load size wrong");
  a_pair_imm: assert property (
    go && opc == OPC_FP && sel == 2'h3 && ld && cod != 2'h0 |=>
    base_update == MLSD_UPD_IMM)
    else $error("pair +imm");
  a_store_imm: assert property (
    go && opc == OPC_FP_IMM && row == ROW_STORE |=>
    op_class == MLSD_OP_FP_STORE && base_update == MLSD_UPD_IMM &&
    update_imm == {$past(instr[36]), $past(instr[27]), $past(instr[12:6])})
    else $error("fp store +imm wrong");
  a_hold_frozen: assert property (!clk_en |=> $stable(op_class) &&
    $stable(access_bytes) && $stable(dec_valid)) else $error("not frozen");
  c_pair: cover property (dec_valid && op_class == MLSD_OP_FP_PAIR_LOAD);
  c_illegal: cover property (illegal_op);
  c_imm: cover property (dec_valid && base_update == MLSD_UPD_IMM);
endmodule // mlsd_decode_chk
bind mlsd_decode mlsd_decode_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
  .dec_valid(dec_valid), .op_class(op_class), .op_variant(op_variant),
  .base_update(base_update), .access_bytes(access_bytes),
  .locality_hint(locality_hint), .update_imm(update_imm),
  .is_load(is_load), .is_store(is_store), .illegal_op(illegal_op));

/* verif/mlsd_issue_model.sv */
`timescale 1ns/1ps
module mlsd_issue_model (
  input  wire logic                    clk_sys,
  input  wire logic [mlsd_pkg::IW-1:0] req_word,
  input  wire logic                    req_valid,
  input  wire logic                    req_en,
  output logic      [mlsd_pkg::IW-1:0] instr,
  output logic                         instr_valid,
  output logic                         clk_en
);
  import mlsd_pkg::*;
  logic [IW-1:0] hw;
  logic          hv;
  logic          he;
  initial begin
    instr = '0;
    instr_valid = 1'b0;
    clk_en = 1'b1;
  end
  always @(posedge clk_sys) begin
    hw <= req_word;
    hv <= req_valid;
    he <= req_en;
  end
  // An idle slot carries the previous word inverted so a stale word cannot pass
  always @(posedge clk_sys) begin
    #1;
    instr = hv ? hw : ~instr;
    instr_valid = hv;
    clk_en = he;
  end
endmodule // mlsd_issue_model

/* verif/memory_unit_load_store_decode_tb_top.sv */
`timescale 1ns/1ps
module memory_unit_load_store_decode_tb_top;
  import mlsd_pkg::*;
  logic clk_sys, rst_b, clk_en, instr_valid, nv, ne, dec_valid, cv, ce, cr;
  logic is_load, is_store, illegal_op;
  logic [IW-1:0] instr, nw, cw;
  mlsd_op_e      op_class;
  mlsd_var_e     op_variant;
  mlsd_upd_e     base_update;
  logic [4:0]    access_bytes;
  logic [1:0]    locality_hint;
  logic [8:0]    update_imm;
  logic [2:0]    eh;
  logic [23:0]   ev, em;
  int            bad_count, compares;
  logic [11:0]   corner [24] = '{12'h402, 12'h414, 12'h430, 12'h437,
    12'h418, 12'h45C, 12'h452, 12'h4C0, 12'h4B0, 12'h487, 12'h504, 12'h530,
    12'h602, 12'h630, 12'h641, 12'h642, 12'h643, 12'h640, 12'h65C, 12'h6C2,
    12'h6B0, 12'h7F0, 12'h002, 12'hF02};
  mlsd_decode dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .dec_valid(dec_valid),
    .op_class(op_class), .op_variant(op_variant), .base_update(base_update),
    .access_bytes(access_bytes), .locality_hint(locality_hint),
    .update_imm(update_imm), .is_load(is_load), .is_store(is_store),
    .illegal_op(illegal_op));
  mlsd_issue_model u_issue (.clk_sys(clk_sys), .req_word(nw),
    .req_valid(nv), .req_en(ne), .instr(instr), .instr_valid(instr_valid),
    .clk_en(clk_en));
  function automatic logic [23:0] dec_exp(logic [IW-1:0] w);
    logic [3:0] o, r;
    logic [1:0] g, c, u;
    logic [4:0] b;
    mlsd_op_e   k;
    o = w[40:37]; r = w[35:32]; c = w[31:30]; k = MLSD_OP_NONE;
    b = 5'h01 << c;
    g = o[0] ? 2'h0 : {w[36], w[27]};
    u = o[0] ? MLSD_UPD_IMM : (g == 2'h2 ? MLSD_UPD_REG : MLSD_UPD_NONE);
    if (o[3:1] == 3'h2) begin
      if (g == 2'h1) begin
        k = r == 4'h7 ? MLSD_OP_FP_TO_GR : MLSD_OP_SEMAPHORE;
        if (r == 4'h7) b = 5'h08;
      end else if (g != 2'h3 && r <= 4'h5) k = MLSD_OP_INT_LOAD;
      else if (g == 2'h0 && r[3:1] == 3'h6) k = MLSD_OP_INT_STORE;
    end else if (o[3:1] == 3'h3) begin
      b = c == 2'h2 ? 5'h04 : (c == 2'h0 ? 5'h10 : 5'h08);
      if (g[0]) begin
        if (g == 2'h1 && r == 4'h7) begin
          k = MLSD_OP_GR_TO_FP;
          b = 5'h08;
        end else if (r <= 4'h5 && c != 2'h0) begin
          k = MLSD_OP_FP_PAIR_LOAD;
          b = c == 2'h2 ? 5'h08 : 5'h10;
          if (g == 2'h3) u = MLSD_UPD_IMM;
        end
      end else if (r <= 4'h5) k = MLSD_OP_FP_LOAD;
      else if (g == 2'h0 && r == 4'hC) k = MLSD_OP_FP_STORE;
    end
    return {k == MLSD_OP_NONE, k, b, u, r[2:0], w[36], w[27],
      r > 4'h5 ? w[12:6] : w[19:13]};
  endfunction
  // Semaphores read and write memory, so they count on both sides
  function automatic logic [1:0] ld_st(logic [3:0] k);
    return {(k inside {MLSD_OP_INT_LOAD, MLSD_OP_FP_LOAD,
      MLSD_OP_FP_PAIR_LOAD, MLSD_OP_SEMAPHORE}),
      (k inside {MLSD_OP_INT_STORE, MLSD_OP_FP_STORE, MLSD_OP_SEMAPHORE})};
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic issue(input logic [IW-1:0] w, input logic v, input logic e);
    @(posedge clk_sys);
    #1;
    nw = w; nv = v; ne = e;
  endtask
  task automatic rand_run(input int n);
    repeat (n) issue({($urandom % 8 == 0) ? 4'($urandom) : {2'h1,
      2'($urandom)}, 5'($urandom), 32'($urandom)}, $urandom % 8 != 0,
      $urandom % 6 != 0);
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cw = instr; cv = instr_valid; ce = clk_en;
    cr = rst_b;
    #2;
    // Reset seen at the edge or asserted just after it clears the outputs
    if (!cr || !rst_b) begin
      eh = '0; ev = '0; em = 24'h800000;
    end else if (ce) begin
      ev = dec_exp(cw);
      eh = {cv && cw[40:39] == 2'h1, cw[29:28]};
      ev[23] = ev[23] & eh[2];
      em = 24'h800000;
      if (eh[2] && !ev[23]) em = {12'hFFF, ev[22:19] == MLSD_OP_INT_LOAD ?
        3'h7 : 3'h0, cw[37] ? 9'h1FF : 9'h000};
    end
    check({dec_valid, locality_hint}, eh);
    check(illegal_op, ev[23]);
    check({op_class, access_bytes, base_update} & em[22:12],
      ev[22:12] & em[22:12]);
    check(op_variant & em[11:9], ev[11:9] & em[11:9]);
    check(update_imm & em[8:0], ev[8:0] & em[8:0]);
    check({is_load, is_store}, ld_st(ev[22:19]));
  end
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0; nw = '0; nv = 1'b0; ne = 1'b1;
    bad_count = 0; compares = 0;
    void'($urandom(32'h03C5BC21));
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    foreach (corner[i]) issue({corner[i][11:7], corner[i][5:0], 2'(i),
      corner[i][6], 27'h2AB3C5D}, 1'b1, 1'b1);
    for (int i = 0; i < 24; i++)
      issue({5'h08, 6'(i), 2'h3, 1'b0, 27'h0}, 1'b1, 1'b1);
    $display("test corner words done");
    rand_run(600);
    $display("test random stream done");
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    rand_run(2);
    @(posedge clk_sys);
    #1 rst_b = 1'b1;
    rand_run(100);
    repeat (4) issue('0, 1'b0, 1'b1);
    $display("test reset mid-run done");
    end_of_test();
  end
endmodule // memory_unit_load_store_decode_tb_top
